// ==== hw/hpas_pkg.sv ====
// package: constants, types and mode tables for the hdmi pattern and audio source
package hpas_pkg;
  // clock
  localparam int MCLK_KHZ = 250000;
  localparam int MCLK_MHZ = 250;
  // apb register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_AUDIO = 8'h10;
  localparam int CTRL_RECFG_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_HPD_BIT = 5;
  localparam int ST_AUDEN_BIT = 6;
  localparam int INT_W = 4;
  localparam int INT_CFG_DONE = 0;
  localparam int INT_HPD = 1;
  localparam int INT_MODE = 2;
  localparam int INT_NACK = 3;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  localparam logic [7:0] AUDIO_RST = 8'h20;
  // display modes
  localparam logic [2:0] MODE_LAST = 3'h4;
  localparam logic [11:0] H_BLANK = 12'h0A0;
  localparam logic [11:0] H_SYNC_ST = 12'h010;
  localparam logic [11:0] H_SYNC_W = 12'h020;
  localparam logic [11:0] V_BLANK = 12'h01E;
  localparam logic [11:0] V_SYNC_ST = 12'h003;
  localparam logic [11:0] V_SYNC_W = 12'h005;
  // i2c configuration
  localparam int I2C_KHZ = 100;
  localparam int I2C_QTR_CYC = (MCLK_KHZ + 4 * I2C_KHZ - 1) / (4 * I2C_KHZ);
  localparam logic [4:0] I2C_LAST_BIT = 5'h1A;
  localparam logic [4:0] I2C_ACK_A = 5'h08;
  localparam logic [4:0] I2C_ACK_B = 5'h11;
  localparam logic [7:0] CFG_AUDFMT_REG = 8'h15;
  localparam logic [7:0] CFG_HDMIFMT_REG = 8'hAF;
  localparam logic [2:0] CFG_LEN = 3'h5;
  localparam logic [2:0] CFG_AUD_IDX = 3'h2;
  localparam logic [15:0] CFG_TABLE [5] = '{{8'h41, 8'h10}, {8'h98, 8'h03}, {CFG_AUDFMT_REG, 8'h00},
                                            {8'h16, 8'h30}, {CFG_HDMIFMT_REG, 8'h06}};
  // audio
  localparam int AUD_FS_HZ = 48000;
  localparam int AUD_BITS = 16;
  localparam int AUD_BCLK_TOG_HZ = AUD_FS_HZ * AUD_BITS * 2 * 2;
  localparam int LINK_HZ_DEF = 8000000;
  // push-button debounce
  localparam int DEB_US = 10000;
  localparam int DEB_CYC = DEB_US * MCLK_MHZ;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'h1,
    I2C_START = 4'h2,
    I2C_XFER = 4'h4,
    I2C_STOP = 4'h8
  } hpas_i2c_e;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } hpas_rgb_s;

  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    hpas_rgb_s rgb;
  } hpas_vid_s;

  typedef struct packed {
    logic bclk;
    logic lrclk;
    logic sdata;
  } hpas_i2s_s;

  // pixel clock in kHz per mode
  function automatic logic [17:0] pclk_khz(input logic [2:0] m);
    case (m)
      3'h0: pclk_khz = 18'h061A8;
      3'h1: pclk_khz = 18'h06978;
      3'h2: pclk_khz = 18'h0FDE8;
      3'h3: pclk_khz = 18'h1A5E0;
      default: pclk_khz = 18'h24414;
    endcase
  endfunction : pclk_khz

  // active size {h, v} per mode
  function automatic logic [23:0] act_size(input logic [2:0] m);
    case (m)
      3'h0: act_size = {12'h280, 12'h1E0};
      3'h1: act_size = {12'h2D0, 12'h1E0};
      3'h2: act_size = {12'h400, 12'h300};
      3'h3: act_size = {12'h500, 12'h400};
      default: act_size = {12'h780, 12'h438};
    endcase
  endfunction : act_size
endpackage : hpas_pkg

// ==== hw/hpas_sine_rom.sv ====
// sine lookup, 64 steps per period, built from a quarter-wave table
`timescale 1ns/100ps
module hpas_sine_rom (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] addr,
  output logic [15:0] q
);
  localparam logic [15:0] QTR [17] = '{16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56,
                                       16'h471C, 16'h5133, 16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2,
                                       16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61, 16'h7FFF};
  logic [4:0] idx;
  logic [15:0] mag;

  // mirror the index in odd quadrants
  assign idx = addr[4] ? (5'h10 - {1'b0, addr[3:0]}) : {1'b0, addr[3:0]};
  assign mag = QTR[idx];

  // registered read, negative half negated
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= 16'h0000;
    else
      q <= addr[5] ? (16'h0000 - mag) : mag;
  end
endmodule : hpas_sine_rom

// ==== hw/hpas_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module hpas_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : hpas_sync

// ==== hw/hpas_top.sv ====
// hdmi transmitter source: i2c setup, pattern video, mode control, i2s tone
`timescale 1ns/100ps
// Overview of operation
// - sequencer configures transmitter over i2c
// - hot plug interrupt reruns whole configuration
// - button press switches to another mode
// - pixel pll reprogrammed on each mode change
// - five modes, 25 to 148.5 MHz
// - pixel is 24-bit rgb, red on top
// - tone only while audio switch is 1
// - audio leaves as 16-bit i2s
// - sample words shifted msb first
// - 48 kHz sample rate from audio clock
// - tone read from sine lookup table
// - writes regs 0x41, 0x98, 0x15, 0x16, 0xAF; all five again on change
module hpas_top #(
  parameter int DEBOUNCE_CYC = hpas_pkg::DEB_CYC,
  parameter int LINK_HZ = hpas_pkg::LINK_HZ_DEF,
  parameter int I2C_QTR = hpas_pkg::I2C_QTR_CYC,
  parameter logic [6:0] DEV_ADDR = 7'h20 // arbitrary target address
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic HPD_INT_N,
  input wire logic MODE_STEP_BUTTON_N,
  input wire logic AUDIO_ENABLE_SWITCH,
  input wire logic PIXEL_CLK_IN,
  output logic PLL_RECONF_REQ,
  output logic [17:0] PLL_RECONF_KHZ,
  input wire logic PLL_RECONF_DONE,
  input wire logic AUDIO_CLK_IN,
  output hpas_pkg::hpas_vid_s VIDEO,
  output hpas_pkg::hpas_i2s_s I2S
);
  localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
  localparam logic [7:0] IDLE_HI = 8'h4F; // done, button, hot plug, sda, scl idle high

  logic [7:0] sync_q;
  logic scl_s, sda_s, hpd_n_s, btn_n_s, aud_en_s, pix_s, done_s, aclk_s;
  logic pix_d_r, done_d_r, hpd_d_r, aclk_d_r;
  logic pix_rise, done_rise, hpd_fall, aclk_rise;
  logic btn_stable_r, press_r;
  logic [DBW-1:0] deb_cnt_r;
  logic [2:0] mode_r, mode_nxt;
  logic pll_init_r, pll_req_r, vid_run_r;
  logic [17:0] pll_khz_r;
  logic [11:0] h_r, v_r, hact, vact, htot, vtot;
  hpas_pkg::hpas_vid_s vid_r;
  logic cfg_pend_r, cfg_start, cfg_set, recfg_wr, aud_chg;
  hpas_pkg::hpas_i2c_e i2c_st_r;
  logic [9:0] qcnt_r;
  logic [1:0] phase_r;
  logic [4:0] bit_r;
  logic [2:0] item_r;
  logic tick, stall, scl_low_r, sda_low_r, tx_bit, ack_slot, nack_ev, done_ev;
  logic [15:0] cfg_word;
  logic [26:0] frame;
  logic [24:0] acc_sum;
  logic [23:0] acc_r;
  logic bclk_r, lrclk_r, sdata_r, bclk_tog, bclk_fall;
  logic [4:0] bcnt_r;
  logic [15:0] sample_r, rom_q;
  logic [5:0] rom_addr_r;
  logic apb_setup, apb_wr, mapped;
  logic [31:0] rdata_nxt, prdata_r;
  logic [3:0] int_stat_r, int_mask_r, int_ev, int_clr;
  logic [7:0] audio_r;

  // all pin and foreign-clock inputs pass two flops; idle-high ones inverted so reset equals idle, no false edge
  hpas_sync #(.W(8)) i_hpas_sync (
    .clk(MCLK),
    .rst_n(NRST),
    .d(IDLE_HI ^ {AUDIO_CLK_IN, PLL_RECONF_DONE, PIXEL_CLK_IN, AUDIO_ENABLE_SWITCH, MODE_STEP_BUTTON_N, HPD_INT_N,
        SDA_I, SCL_I}),
    .q(sync_q)
  );
  assign {aclk_s, done_s, pix_s, aud_en_s, btn_n_s, hpd_n_s, sda_s, scl_s} = sync_q ^ IDLE_HI;

  // edge finders on synchronised inputs
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pix_d_r <= 1'b0;
      done_d_r <= 1'b1;
      hpd_d_r <= 1'b1;
      aclk_d_r <= 1'b0;
    end
    else
    begin
      pix_d_r <= pix_s;
      done_d_r <= done_s;
      hpd_d_r <= hpd_n_s;
      aclk_d_r <= aclk_s;
    end
  end
  assign pix_rise = pix_s & ~pix_d_r;
  assign done_rise = done_s & ~done_d_r;
  assign hpd_fall = hpd_d_r & ~hpd_n_s;
  assign aclk_rise = aclk_s & ~aclk_d_r;

  // button debounce, one pulse per press
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      btn_stable_r <= 1'b1;
      deb_cnt_r <= '0;
      press_r <= 1'b0;
    end
    else
    begin
      press_r <= 1'b0;
      if (btn_n_s == btn_stable_r)
        deb_cnt_r <= '0;
      else if (deb_cnt_r == DBW'(DEBOUNCE_CYC - 1))
      begin
        btn_stable_r <= btn_n_s;
        deb_cnt_r <= '0;
        press_r <= ~btn_n_s;
      end
      else
        deb_cnt_r <= deb_cnt_r + 1'b1;
    end
  end

  // mode step with wrap
  assign mode_nxt = (mode_r == hpas_pkg::MODE_LAST) ? 3'h0 : mode_r + 3'h1;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      mode_r <= 3'h0;
    else if (press_r)
      mode_r <= mode_nxt;
  end

  // pixel pll request; video held until pll reports done
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pll_init_r <= 1'b1;
      pll_req_r <= 1'b0;
      pll_khz_r <= 18'h00000;
      vid_run_r <= 1'b0;
    end
    else
    begin
      pll_init_r <= 1'b0;
      pll_req_r <= press_r | pll_init_r;
      pll_khz_r <= hpas_pkg::pclk_khz(press_r ? mode_nxt : mode_r);
      if (pll_req_r)
        vid_run_r <= 1'b0;
      else if (done_rise)
        vid_run_r <= 1'b1;
    end
  end
  assign PLL_RECONF_REQ = pll_req_r;
  assign PLL_RECONF_KHZ = pll_khz_r;

  // raster counters advance on pixel clock edges
  assign {hact, vact} = hpas_pkg::act_size(mode_r);
  assign htot = hact + hpas_pkg::H_BLANK;
  assign vtot = vact + hpas_pkg::V_BLANK;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      h_r <= 12'h000;
      v_r <= 12'h000;
    end
    else if (!vid_run_r)
    begin
      h_r <= 12'h000;
      v_r <= 12'h000;
    end
    else if (pix_rise)
    begin
      if (h_r == htot - 12'h001)
      begin
        h_r <= 12'h000;
        v_r <= (v_r == vtot - 12'h001) ? 12'h000 : v_r + 12'h001;
      end
      else
        h_r <= h_r + 12'h001;
    end
  end

  // pattern and sync outputs, rgb packed red-green-blue
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      vid_r <= '0;
    else if (!vid_run_r)
      vid_r <= '0;
    else if (pix_rise)
    begin
      vid_r.de <= (h_r < hact) && (v_r < vact);
      vid_r.hs <= (h_r >= hact + hpas_pkg::H_SYNC_ST) && (h_r < hact + hpas_pkg::H_SYNC_ST + hpas_pkg::H_SYNC_W);
      vid_r.vs <= (v_r >= vact + hpas_pkg::V_SYNC_ST) && (v_r < vact + hpas_pkg::V_SYNC_ST + hpas_pkg::V_SYNC_W);
      vid_r.rgb <= {h_r[7:0], v_r[7:0], h_r[8:1] ^ v_r[8:1]};
    end
  end
  assign VIDEO = vid_r;

  // configuration request: reset, hot plug, software, audio format change
  assign cfg_set = hpd_fall | recfg_wr | aud_chg;
  assign cfg_start = (i2c_st_r == hpas_pkg::I2C_IDLE) & cfg_pend_r;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      cfg_pend_r <= 1'b1;
    else
      cfg_pend_r <= cfg_set | (cfg_pend_r & ~cfg_start);
  end

  // i2c quarter-bit timer, held while a slave stretches scl
  assign stall = ~scl_low_r & ~scl_s;
  assign tick = (qcnt_r == 10'(I2C_QTR - 1)) & ~stall;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      qcnt_r <= 10'h000;
    else if (i2c_st_r == hpas_pkg::I2C_IDLE || tick)
      qcnt_r <= 10'h000;
    else if (!stall)
      qcnt_r <= qcnt_r + 10'h001;
  end

  // current write: device address, register, data with ack slots
  assign cfg_word = (item_r == hpas_pkg::CFG_AUD_IDX) ? {hpas_pkg::CFG_AUDFMT_REG, audio_r}
                                                      : hpas_pkg::CFG_TABLE[item_r];
  assign frame = {DEV_ADDR, 1'b0, 1'b1, cfg_word[15:8], 1'b1, cfg_word[7:0], 1'b1};
  assign tx_bit = frame[hpas_pkg::I2C_LAST_BIT - bit_r];
  assign ack_slot = (bit_r == hpas_pkg::I2C_ACK_A) || (bit_r == hpas_pkg::I2C_ACK_B) ||
                    (bit_r == hpas_pkg::I2C_LAST_BIT);
  assign nack_ev = (i2c_st_r == hpas_pkg::I2C_XFER) & tick & (phase_r == 2'h2) & ack_slot & sda_s;
  assign done_ev = (i2c_st_r == hpas_pkg::I2C_STOP) & tick & (phase_r == 2'h3) &
                   (item_r == hpas_pkg::CFG_LEN - 3'h1);

  // configuration sequencer walks the table
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      i2c_st_r <= hpas_pkg::I2C_IDLE;
      phase_r <= 2'h0;
      bit_r <= 5'h00;
      item_r <= 3'h0;
    end
    else
    begin
      if (tick)
        phase_r <= phase_r + 2'h1;
      case (i2c_st_r)
        hpas_pkg::I2C_IDLE:
          if (cfg_start)
          begin
            i2c_st_r <= hpas_pkg::I2C_START;
            item_r <= 3'h0;
            phase_r <= 2'h0;
          end
        hpas_pkg::I2C_START:
          if (tick && phase_r == 2'h3)
          begin
            i2c_st_r <= hpas_pkg::I2C_XFER;
            bit_r <= 5'h00;
          end
        hpas_pkg::I2C_XFER:
          if (tick && phase_r == 2'h3)
          begin
            if (bit_r == hpas_pkg::I2C_LAST_BIT)
              i2c_st_r <= hpas_pkg::I2C_STOP;
            else
              bit_r <= bit_r + 5'h01;
          end
        hpas_pkg::I2C_STOP:
          if (tick && phase_r == 2'h3)
          begin
            if (item_r == hpas_pkg::CFG_LEN - 3'h1)
              i2c_st_r <= hpas_pkg::I2C_IDLE;
            else
            begin
              item_r <= item_r + 3'h1;
              i2c_st_r <= hpas_pkg::I2C_START;
            end
          end
        default:
          i2c_st_r <= hpas_pkg::I2C_IDLE;
      endcase
    end
  end

  // open-drain line drivers: start, bits, stop
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else if (tick)
    begin
      case (i2c_st_r)
        hpas_pkg::I2C_START:
          if (phase_r == 2'h1)
            sda_low_r <= 1'b1;
          else if (phase_r == 2'h3)
            scl_low_r <= 1'b1;
        hpas_pkg::I2C_XFER:
          if (phase_r == 2'h0)
            sda_low_r <= ~tx_bit;
          else if (phase_r == 2'h1)
            scl_low_r <= 1'b0;
          else if (phase_r == 2'h3)
            scl_low_r <= 1'b1;
        hpas_pkg::I2C_STOP:
          if (phase_r == 2'h0)
            sda_low_r <= 1'b1;
          else if (phase_r == 2'h1)
            scl_low_r <= 1'b0;
          else if (phase_r == 2'h3)
            sda_low_r <= 1'b0;
        default:
        begin
          scl_low_r <= 1'b0;
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end
  assign SCL_O = 1'b0;
  assign SCL_OE = scl_low_r;
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_low_r;

  // bit clock from audio clock edges by fractional accumulation
  assign acc_sum = {1'b0, acc_r} + 25'(hpas_pkg::AUD_BCLK_TOG_HZ);
  assign bclk_tog = aclk_rise & (acc_sum >= 25'(LINK_HZ));
  assign bclk_fall = bclk_tog & bclk_r;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      acc_r <= 24'h000000;
      bclk_r <= 1'b0;
    end
    else if (aclk_rise)
    begin
      acc_r <= bclk_tog ? 24'(acc_sum - 25'(LINK_HZ)) : acc_sum[23:0];
      if (bclk_tog)
        bclk_r <= ~bclk_r;
    end
  end

  // i2s framing: word select leads the msb by one bit clock
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      bcnt_r <= 5'h00;
      lrclk_r <= 1'b0;
      sdata_r <= 1'b0;
      sample_r <= 16'h0000;
      rom_addr_r <= 6'h00;
    end
    else if (bclk_fall)
    begin
      bcnt_r <= bcnt_r + 5'h01;
      lrclk_r <= bcnt_r[4] ^ (&bcnt_r[3:0]);
      sdata_r <= sample_r[~bcnt_r[3:0]];
      if (bcnt_r == 5'h1F)
      begin
        sample_r <= aud_en_s ? rom_q : 16'h0000;
        rom_addr_r <= rom_addr_r + 6'h01;
      end
    end
  end
  assign I2S = '{bclk: bclk_r, lrclk: lrclk_r, sdata: sdata_r};

  // tone table
  hpas_sine_rom i_hpas_sine_rom (
    .clk(MCLK),
    .rst_n(NRST),
    .addr(rom_addr_r),
    .q(rom_q)
  );

  // apb decode, zero wait states
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr = PSEL & PENABLE & PWRITE & mapped;
  assign mapped = (PADDR == hpas_pkg::REG_CTRL) || (PADDR == hpas_pkg::REG_STATUS) ||
                  (PADDR == hpas_pkg::REG_INT_STAT) || (PADDR == hpas_pkg::REG_INT_MASK) ||
                  (PADDR == hpas_pkg::REG_AUDIO);
  assign recfg_wr = apb_wr & (PADDR == hpas_pkg::REG_CTRL) & PWDATA[hpas_pkg::CTRL_RECFG_BIT];
  assign aud_chg = apb_wr & (PADDR == hpas_pkg::REG_AUDIO) & (PWDATA[7:0] != audio_r);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // read mux
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    case (PADDR)
      hpas_pkg::REG_STATUS:
      begin
        rdata_nxt[hpas_pkg::ST_MODE_LSB +: 3] = mode_r;
        rdata_nxt[hpas_pkg::ST_BUSY_BIT] = (i2c_st_r != hpas_pkg::I2C_IDLE) | cfg_pend_r;
        rdata_nxt[hpas_pkg::ST_RUN_BIT] = vid_run_r;
        rdata_nxt[hpas_pkg::ST_HPD_BIT] = ~hpd_n_s;
        rdata_nxt[hpas_pkg::ST_AUDEN_BIT] = aud_en_s;
      end
      hpas_pkg::REG_INT_STAT: rdata_nxt[3:0] = int_stat_r;
      hpas_pkg::REG_INT_MASK: rdata_nxt[3:0] = int_mask_r;
      hpas_pkg::REG_AUDIO: rdata_nxt[7:0] = audio_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      prdata_r <= 32'h00000000;
    else if (apb_setup)
      prdata_r <= rdata_nxt;
  end
  assign PRDATA = prdata_r;

  // writable registers
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      int_mask_r <= hpas_pkg::INT_MASK_RST;
      audio_r <= hpas_pkg::AUDIO_RST;
    end
    else if (apb_wr)
    begin
      if (PADDR == hpas_pkg::REG_INT_MASK)
        int_mask_r <= PWDATA[3:0];
      if (PADDR == hpas_pkg::REG_AUDIO)
        audio_r <= PWDATA[7:0];
    end
  end

  // sticky events, write one to clear, a new event wins
  assign int_ev = {nack_ev, press_r, hpd_fall, done_ev};
  assign int_clr = (apb_wr && PADDR == hpas_pkg::REG_INT_STAT) ? PWDATA[3:0] : 4'h0;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      int_stat_r <= 4'h0;
    else
      int_stat_r <= int_ev | (int_stat_r & ~int_clr);
  end
  assign IRQ = |(int_stat_r & int_mask_r);

  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  mode_step_a: assert property (press_r && mode_r != hpas_pkg::MODE_LAST |=> mode_r == $past(mode_r) + 3'h1)
    else $error("mode did not step on press");
  mode_wrap_a: assert property (press_r && mode_r == hpas_pkg::MODE_LAST |=> mode_r == 3'h0)
    else $error("mode did not wrap to zero");
  pll_freq_a: assert property (press_r |=> PLL_RECONF_REQ && PLL_RECONF_KHZ == hpas_pkg::pclk_khz(mode_r))
    else $error("pll request missing or wrong frequency");
  video_hold_a: assert property (PLL_RECONF_REQ |=> !vid_run_r ##1 !VIDEO.de)
    else $error("video ran during pll change");
  rgb_pack_a: assert property (vid_run_r && pix_rise |=> VIDEO.rgb.r == $past(h_r[7:0]))
    else $error("red byte not in top of pixel");
  hpd_rerun_a: assert property (hpd_fall |=> cfg_pend_r ##[1:3] i2c_st_r != hpas_pkg::I2C_IDLE)
    else $error("hot plug did not restart configuration");
  reg15_word_a: assert property (i2c_st_r == hpas_pkg::I2C_XFER && item_r == hpas_pkg::CFG_AUD_IDX
                                 |-> frame[17:10] == hpas_pkg::CFG_AUDFMT_REG && frame[8:1] == audio_r)
    else $error("audio format register write is wrong");
  msb_first_a: assert property (bclk_fall && bcnt_r == 5'h00 |=> I2S.sdata == $past(sample_r[15]))
    else $error("sample msb not first");
  lr_lead_a: assert property (bclk_fall && bcnt_r == 5'h0F |=> I2S.lrclk && I2S.sdata == $past(sample_r[0]))
    else $error("word select not one bit ahead");
  mute_a: assert property (bclk_fall && bcnt_r == 5'h1F && !aud_en_s |=> sample_r == 16'h0000)
    else $error("tone sent with audio disabled");
  cfg_go_a: assert property (cfg_start |=> i2c_st_r == hpas_pkg::I2C_START)
    else $error("configuration did not start");

  mode_cov: cover property (press_r && mode_r == hpas_pkg::MODE_LAST);
  hpd_cov: cover property (hpd_fall ##[1:8] i2c_st_r == hpas_pkg::I2C_START);
  tone_cov: cover property (bclk_fall && bcnt_r == 5'h1F && aud_en_s);
endmodule : hpas_top

// ==== verif/hpas_xmtr_model.sv ====
// transmitter-side model: i2c target with ack, pixel pll, pixel clock
`timescale 1ns/100ps
module hpas_xmtr_model (
  input wire logic clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic req,
  output logic scl,
  output logic sda,
  output logic done,
  output logic pix,
  output logic [7:0] byte0,
  output logic got
);
  logic ack_oe = 1'b0;
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  int nb = 9;
  int wt = 0;
  logic slow = 1'b0;
  // pulled-up open-drain lines
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | ack_oe);
  initial done = 1'b1;
  initial pix = 1'b0;
  initial byte0 = 8'h00;
  initial got = 1'b0;
  // pixel clock edges kept off the mclk edges
  initial #1 forever #6 pix = ~pix;
  // bits on scl rise, ack on ninth clock
  always @(posedge clk)
  begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && sda_d && !sda)
      nb <= 0;
    else if (scl && !scl_d && nb < 8)
    begin
      nb <= nb + 1;
      if (!got)
        byte0 <= {byte0[6:0], sda};
    end
    else if (!scl && scl_d && nb == 8)
    begin
      ack_oe <= 1'b1;
      nb <= 9;
    end
    else if (!scl && scl_d && nb == 9 && ack_oe)
    begin
      ack_oe <= 1'b0;
      got <= 1'b1;
      nb <= 0;
    end
  end
  // pll relock, alternately quick and slow
  always @(posedge clk)
  begin
    if (req)
    begin
      done <= 1'b0;
      wt <= slow ? 40 : 3;
      slow <= ~slow;
    end
    else if (wt > 0)
    begin
      wt <= wt - 1;
      done <= (wt == 1);
    end
  end
endmodule : hpas_xmtr_model

// ==== verif/tb_hpas_top.sv ====
// self-checking bench: apb registers, interrupts, mode stepping, pll, i2c
`timescale 1ns/100ps
module tb_hpas_top;
  localparam logic [17:0] KHZ [5] = '{18'h061A8, 18'h06978, 18'h0FDE8, 18'h1A5E0, 18'h24414};
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic AUDIO_CLK_IN = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [31:0] PWDATA = 32'h0;
  logic HPD_INT_N = 1'b1;
  logic MODE_STEP_BUTTON_N = 1'b1;
  logic AUDIO_ENABLE_SWITCH = 1'b1;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, IRQ, SCL_O, SCL_OE, SDA_O, SDA_OE, scl, sda, done, pix, got, PLL_RECONF_REQ;
  logic [17:0] PLL_RECONF_KHZ;
  logic [7:0] byte0;
  hpas_pkg::hpas_vid_s VIDEO;
  hpas_pkg::hpas_i2s_s I2S;
  logic [32:0] rd_q[$];
  logic [32:0] pll_q[$];
  logic [31:0] seed = 32'h4;
  int n_errors = 0;
  int n_checks = 0;
  int k;
  int w;
  int ones = 0;
  always #2 MCLK = ~MCLK;
  always #62.5 AUDIO_CLK_IN = ~AUDIO_CLK_IN;
  hpas_top #(.DEBOUNCE_CYC(16), .I2C_QTR(20)) i_hpas_top (.MCLK(MCLK), .NRST(NRST), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
    .HPD_INT_N(HPD_INT_N), .MODE_STEP_BUTTON_N(MODE_STEP_BUTTON_N), .AUDIO_ENABLE_SWITCH(AUDIO_ENABLE_SWITCH),
    .PIXEL_CLK_IN(pix), .PLL_RECONF_REQ(PLL_RECONF_REQ), .PLL_RECONF_KHZ(PLL_RECONF_KHZ),
    .PLL_RECONF_DONE(done), .AUDIO_CLK_IN(AUDIO_CLK_IN), .VIDEO(VIDEO), .I2S(I2S));
  hpas_xmtr_model i_hpas_xmtr_model (.clk(MCLK), .scl_oe(SCL_OE), .sda_oe(SDA_OE), .req(PLL_RECONF_REQ),
    .scl(scl), .sda(sda), .done(done), .pix(pix), .byte0(byte0), .got(got));
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // xorshift random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift
  // one apb transfer, reads note their expected {pslverr, prdata}
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!w)
      rd_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
    if (n >= 50)
    begin
      n_errors++;
      results();
    end
  endtask : apb
  // results seen at the ports against the oldest note
  always @(posedge MCLK)
  begin
    if (PSEL && PENABLE && PREADY && !PWRITE && rd_q.size() > 0)
      check("apb read", {PSLVERR, PRDATA}, rd_q.pop_front());
    if (PLL_RECONF_REQ === 1'b1)
      check("pll khz", {15'h0, PLL_RECONF_KHZ}, pll_q.size() > 0 ? pll_q.pop_front() : 33'h1FFFFFFFF);
    if (I2S.sdata === 1'b1)
      ones++;
  end
  initial
  begin
    pll_q.push_back({15'h0, KHZ[0]});
    repeat (4) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (100) @(posedge MCLK);
    apb(1'b0, hpas_pkg::REG_STATUS, 32'h0, 33'h58);
    apb(1'b0, hpas_pkg::REG_INT_MASK, 32'h0, 33'h0);
    apb(1'b0, hpas_pkg::REG_AUDIO, 32'h0, 33'h20);
    apb(1'b1, 8'h24, 32'hFF, 33'h0);
    apb(1'b0, 8'h24, 32'h0, 33'h100000000);
    apb(1'b1, hpas_pkg::REG_AUDIO, 32'h21, 33'h0);
    apb(1'b0, hpas_pkg::REG_AUDIO, 32'h0, 33'h21);
    apb(1'b1, hpas_pkg::REG_CTRL, 32'h1, 33'h0);
    $display("test reset and map done");
    for (k = 1; k <= 5; k++)
    begin
      pll_q.push_back({15'h0, KHZ[k % 5]});
      MODE_STEP_BUTTON_N <= 1'b0;
      repeat (40) @(posedge MCLK);
      MODE_STEP_BUTTON_N <= 1'b1;
      repeat (100) @(posedge MCLK);
      apb(1'b0, hpas_pkg::REG_STATUS, 32'h0, 33'h58 | (k % 5));
    end
    $display("test mode stepping done");
    seed = xorshift(seed);
    apb(1'b1, hpas_pkg::REG_INT_MASK, seed, 33'h0);
    apb(1'b0, hpas_pkg::REG_INT_MASK, 32'h0, {29'h0, seed[3:0]});
    check("irq random mask", IRQ, seed[2]);
    apb(1'b1, hpas_pkg::REG_INT_MASK, 32'h4, 33'h0);
    apb(1'b0, hpas_pkg::REG_INT_STAT, 32'h0, 33'h4);
    check("irq unmasked", IRQ, 1'b1);
    apb(1'b1, hpas_pkg::REG_INT_STAT, 32'hF, 33'h0);
    check("irq cleared", IRQ, 1'b0);
    HPD_INT_N <= 1'b0;
    repeat (10) @(posedge MCLK);
    HPD_INT_N <= 1'b1;
    apb(1'b0, hpas_pkg::REG_INT_STAT, 32'h0, 33'h2);
    check("irq hpd masked", IRQ, 1'b0);
    $display("test interrupts done");
    k = 0;
    while (got !== 1'b1 && k < 40000)
    begin
      @(posedge MCLK);
      k++;
    end
    check("i2c address byte", byte0, 8'h40);
    check("i2c ack seen", got, 33'h1);
    $display("test i2c address done");
    k = 0;
    while (VIDEO.de !== 1'b0 && k < 9000)
    begin
      @(posedge MCLK);
      k++;
    end
    while (VIDEO.de !== 1'b1 && k < 9000)
    begin
      @(posedge MCLK);
      k++;
    end
    w = 0;
    while (VIDEO.de === 1'b1 && w < 9000)
    begin
      @(posedge MCLK);
      w++;
    end
    check("active line cycles", w, 33'h780);
    $display("test video line done");
    AUDIO_ENABLE_SWITCH <= 1'b0;
    repeat (12000) @(posedge MCLK);
    ones = 0;
    repeat (6000) @(posedge MCLK);
    check("muted data ones", ones, 33'h0);
    AUDIO_ENABLE_SWITCH <= 1'b1;
    repeat (12000) @(posedge MCLK);
    ones = 0;
    repeat (6000) @(posedge MCLK);
    check("tone present", ones != 0, 33'h1);
    apb(1'b0, hpas_pkg::REG_INT_STAT, 32'h0, 33'h3);
    $display("test audio and config done");
    check("queues drained", rd_q.size() + pll_q.size(), 33'h0);
    results();
  end
endmodule : tb_hpas_top
